// File: rtl/bmw_cfg.svh
// constants for the bridge memory window register bank
`ifndef BMW_CFG_SVH
`define BMW_CFG_SVH
`define BMW_OFS_MEM 8'h20
`define BMW_OFS_PF_LOW 8'h24
`define BMW_OFS_PF_BASE_HI 8'h28
`define BMW_OFS_PF_LIMIT_HI 8'h2c
`define BMW_PF_CAP_64 4'h1
`define BMW_ZERO_20 20'h00000
`define BMW_ONES_20 20'hfffff
`define BMW_BASE_LSB 4
`define BMW_BASE_MSB 15
`define BMW_LIMIT_LSB 20
`define BMW_LIMIT_MSB 31
`define BMW_CAPLO_MSB 3
`define BMW_CAPHI_LSB 16
`define BMW_CAPHI_MSB 19
`endif

// File: rtl/bmw_pkg.sv
// types for the bridge memory window register bank
package bmw_pkg;
  typedef logic [11:0] bmw_field_t;
  typedef struct packed {
    logic [11:0] mem_base;
    logic [11:0] mem_limit;
    logic [11:0] pf_base;
    logic [11:0] pf_limit;
    logic [31:0] pf_base_hi;
    logic [31:0] pf_limit_hi;
    logic [31:0] rdata;
  } bmw_state_s;
endpackage

// File: rtl/bmw_range_cmp.sv
// inclusive range comparator for one address window
module bmw_range_cmp #(
  parameter int AW = 64
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW-1:0] bottom,
  input wire logic [AW-1:0] top,
  output logic hit
);
  assign hit = (addr >= bottom) && (addr <= top);
endmodule

// File: rtl/bmw_regs.sv
// memory window configuration registers with apb slave and forwarding decode
//
// Function
// - the low nibbles of the memory base and limit fields read zero and reset to zero.
// - the memory base field gives window bottom bits 31:20 with bits 19:0 zero, reset zero.
// - the memory limit field gives window top bits 31:20 with bits 19:0 all ones.
// - memory transactions are forwarded according to the memory base and limit.
// - the prefetchable low nibbles encode addressing capability, 0 for 32-bit, 1 for 64-bit.
// - each prefetchable capability nibble resets to one, reporting 64-bit support.
// - the prefetchable base field gives bottom bits 31:20 with lower twenty bits zero.
// - the prefetchable limit field gives top bits 31:20 with lower bits ones, for reads and writes.
// - a writable 32-bit register holds prefetchable bottom bits 63:32, reset zero.
// - a writable 32-bit register holds prefetchable top bits 63:32, reset zero.
//
// Design decision made here: the APB register port.
`include "bmw_cfg.svh"
module bmw_regs #(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [63:0] txn_addr,
  input wire logic txn_is_64,
  output logic mem_hit,
  output logic pf_hit,
  output logic forward
);
  // ==========================================================
  // state
  bmw_pkg::bmw_state_s st_r;
  bmw_pkg::bmw_state_s st_nxt;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic mapped;
  logic [63:0] mem_bottom;
  logic [63:0] mem_top;
  logic [63:0] pf_bottom;
  logic [63:0] pf_top;
  logic [63:0] mem_addr;
  logic mem_hit_c;
  logic pf_hit_c;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // ==========================================================
  // byte strobe expansion
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
    end
  endgenerate

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      AW'(`BMW_OFS_MEM): begin
        rd_mux[`BMW_BASE_MSB:`BMW_BASE_LSB] = st_r.mem_base;
        rd_mux[`BMW_LIMIT_MSB:`BMW_LIMIT_LSB] = st_r.mem_limit;
      end
      AW'(`BMW_OFS_PF_LOW): begin
        rd_mux[`BMW_CAPLO_MSB:0] = `BMW_PF_CAP_64;
        rd_mux[`BMW_BASE_MSB:`BMW_BASE_LSB] = st_r.pf_base;
        rd_mux[`BMW_CAPHI_MSB:`BMW_CAPHI_LSB] = `BMW_PF_CAP_64;
        rd_mux[`BMW_LIMIT_MSB:`BMW_LIMIT_LSB] = st_r.pf_limit;
      end
      AW'(`BMW_OFS_PF_BASE_HI): rd_mux = st_r.pf_base_hi;
      AW'(`BMW_OFS_PF_LIMIT_HI): rd_mux = st_r.pf_limit_hi;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] cur;
    logic [31:0] nw;
    cur = rd_mux;
    nw = (pwdata & wmask) | (cur & ~wmask);
    st_nxt = st_r;
    if (rd_en) begin
      st_nxt.rdata = mapped ? rd_mux : 32'h0000_0000;
    end
    if (wr_en && mapped) begin
      unique case (paddr)
        AW'(`BMW_OFS_MEM): begin
          st_nxt.mem_base = nw[`BMW_BASE_MSB:`BMW_BASE_LSB];
          st_nxt.mem_limit = nw[`BMW_LIMIT_MSB:`BMW_LIMIT_LSB];
        end
        AW'(`BMW_OFS_PF_LOW): begin
          st_nxt.pf_base = nw[`BMW_BASE_MSB:`BMW_BASE_LSB];
          st_nxt.pf_limit = nw[`BMW_LIMIT_MSB:`BMW_LIMIT_LSB];
        end
        AW'(`BMW_OFS_PF_BASE_HI): st_nxt.pf_base_hi = nw;
        AW'(`BMW_OFS_PF_LIMIT_HI): st_nxt.pf_limit_hi = nw;
        default: st_nxt = st_nxt;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;

  // ==========================================================
  // window assembly and decode
  assign mem_bottom = {32'h0000_0000, st_r.mem_base, `BMW_ZERO_20};
  assign mem_top = {32'h0000_0000, st_r.mem_limit, `BMW_ONES_20};
  assign pf_bottom = {st_r.pf_base_hi, st_r.pf_base, `BMW_ZERO_20};
  assign pf_top = {st_r.pf_limit_hi, st_r.pf_limit, `BMW_ONES_20};
  // 32-bit addresses sit in the low half; the plain window never decodes above 4 GB
  assign mem_addr = txn_is_64 ? txn_addr : {32'h0000_0000, txn_addr[31:0]};

  bmw_range_cmp #(.AW(64)) u_mem_cmp (
    .addr(mem_addr),
    .bottom(mem_bottom),
    .top(mem_top),
    .hit(mem_hit_c)
  );

  bmw_range_cmp #(.AW(64)) u_pf_cmp (
    .addr(mem_addr),
    .bottom(pf_bottom),
    .top(pf_top),
    .hit(pf_hit_c)
  );

  assign mem_hit = mem_hit_c;
  assign pf_hit = pf_hit_c;
  assign forward = mem_hit_c || pf_hit_c;

  // ==========================================================
  // assertions
  AST_MEM_LOW_NIBBLE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == AW'(`BMW_OFS_MEM)) |=>
    (prdata[3:0] == 4'h0 && prdata[19:16] == 4'h0))
    else $error("memory window low nibbles not zero");
  AST_MEM_BASE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == AW'(`BMW_OFS_MEM) && pstrb == 4'hf) |=>
    (mem_bottom[31:20] == $past(pwdata[15:4]) && mem_bottom[19:0] == 20'h00000))
    else $error("memory bottom not taken from write");
  AST_MEM_TOP_ONES: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == AW'(`BMW_OFS_MEM) && pstrb == 4'hf) |=>
    (mem_top[31:20] == $past(pwdata[31:20]) && mem_top[19:0] == 20'hfffff))
    else $error("memory top not taken from write");
  AST_FORWARD_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
    forward == ((mem_addr >= mem_bottom && mem_addr <= mem_top) ||
    (mem_addr >= pf_bottom && mem_addr <= pf_top)))
    else $error("forward decision mismatch");
  AST_PF_CAP_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == AW'(`BMW_OFS_PF_LOW)) |=>
    (prdata[3:0] == 4'h1 && prdata[19:16] == 4'h1))
    else $error("prefetch capability nibble wrong");
  AST_PF_CAP_AFTER_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == AW'(`BMW_OFS_PF_LOW)) ##2 (rd_en && paddr == AW'(`BMW_OFS_PF_LOW)) |=>
    (prdata[3:0] == 4'h1))
    else $error("capability nibble changed by write");
  AST_PF_BASE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == AW'(`BMW_OFS_PF_LOW) && pstrb == 4'hf) |=>
    (pf_bottom[31:20] == $past(pwdata[15:4]) && pf_top[31:20] == $past(pwdata[31:20])))
    else $error("prefetch low fields not taken");
  AST_PF_TOP_ONES: assert property (@(posedge pclk) disable iff (!presetn)
    pf_top[19:0] == 20'hfffff && pf_bottom[19:0] == 20'h00000)
    else $error("prefetch window low bits wrong");
  AST_PF_BASE_HI: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == AW'(`BMW_OFS_PF_BASE_HI) && pstrb == 4'hf) |=>
    (pf_bottom[63:32] == $past(pwdata)) ##1 $stable(pf_bottom[63:32]))
    else $error("prefetch base upper not held");
  AST_PF_LIMIT_HI: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == AW'(`BMW_OFS_PF_LIMIT_HI) && pstrb == 4'hf) |=>
    (pf_top[63:32] == $past(pwdata)))
    else $error("prefetch limit upper not taken");
  AST_PF_HIT_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    pf_hit |-> (mem_addr >= pf_bottom && mem_addr <= pf_top))
    else $error("prefetch hit outside window");

  COV_MEM_HIT: cover property (@(posedge pclk) disable iff (!presetn) mem_hit);
  COV_PF_HIT_HIGH: cover property (@(posedge pclk) disable iff (!presetn)
    pf_hit && mem_addr[63:32] != 32'h0000_0000);
  COV_UNMAPPED: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  COV_WR_THEN_RD: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en ##2 rd_en);
endmodule

// File: dv/tb_bridge_memory_window_regs.sv
// self-checking bench for the memory window register bank
module tb_bridge_memory_window_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, txn_is_64, pready, pslverr;
  logic mem_hit, pf_hit, forward, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, pbh, plh;
  logic [3:0] pstrb;
  logic [63:0] txn_addr, a;
  logic [11:0] mb, ml, pb, pl;
  logic [1:0] ex;
  int err_total, compares;
  bmw_regs #(.AW(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txn_addr(txn_addr), .txn_is_64(txn_is_64),
    .mem_hit(mem_hit), .pf_hit(pf_hit), .forward(forward));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; waits for pready, takes data and response at that edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [1:0] exp_hit(input logic [63:0] x, input logic w64);
    logic [63:0] v;
    logic m, p;
    v = w64 ? x : {32'h00000000, x[31:0]};
    m = v[63:32] == 32'h00000000 && v[31:0] >= {mb, 20'h00000} && v[31:0] <= {ml, 20'hfffff};
    p = v >= {pbh, pb, 20'h00000} && v <= {plh, pl, 20'hfffff};
    return {m, p};
  endfunction
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, txn_is_64, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    txn_addr = 64'h0000000000000000;
    rd = $urandom(32'h78345633);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b0, 8'h24, 32'h00000000);
    chk(rd, 32'h00010001);
    apb(1'b0, 8'h28, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b0, 8'h2c, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b1, 8'h24, 32'h00000000);
    apb(1'b0, 8'h24, 32'h00000000);
    chk(rd, 32'h00010001);
    apb(1'b1, 8'h30, 32'hffffffff);
    chk(er, 32'h00000001);
    apb(1'b0, 8'h30, 32'h00000000);
    chk(rd, 32'h00000000);
    for (int i = 0; i < 30; i++) begin
      d = (i == 0) ? 32'hffffffff : $urandom;
      apb(1'b1, 8'h20, d);
      mb = d[15:4];
      ml = d[31:20];
      apb(1'b0, 8'h20, 32'h00000000);
      chk(rd, {ml, 4'h0, mb, 4'h0});
      chk(er, 32'h00000000);
      d = (i == 0) ? 32'hffffffff : $urandom;
      apb(1'b1, 8'h24, d);
      pb = d[15:4];
      pl = d[31:20];
      apb(1'b0, 8'h24, 32'h00000000);
      chk(rd, {pl, 4'h1, pb, 4'h1});
      pbh = $urandom % 3;
      plh = pbh + $urandom % 2;
      apb(1'b1, 8'h28, pbh);
      apb(1'b1, 8'h2c, plh);
      apb(1'b0, 8'h28, 32'h00000000);
      chk(rd, pbh);
      apb(1'b0, 8'h2c, 32'h00000000);
      chk(rd, plh);
      // partial byte-lane write merges with the held word
      pstrb <= 4'($urandom);
      d = $urandom;
      apb(1'b1, 8'h2c, d);
      for (int b = 0; b < 4; b++) if (pstrb[b]) plh[b*8 +: 8] = d[b*8 +: 8];
      pstrb <= 4'hf;
      apb(1'b0, 8'h2c, 32'h00000000);
      chk(rd, plh);
      // window edges and their neighbours
      for (int k = 0; k < 8; k++) begin
        a = (k < 2) ? {32'h00000000, mb, 20'h00000} : (k < 4) ? {32'h00000000, ml, 20'hfffff} :
            (k < 6) ? {pbh, pb, 20'h00000} : {plh, pl, 20'hfffff};
        if (k % 2 == 1) a = (k % 4 == 1) ? a - 64'h1 : a + 64'h1;
        @(posedge pclk);
        txn_addr <= a;
        txn_is_64 <= 1'($urandom);
        @(negedge pclk);
        ex = exp_hit(txn_addr, txn_is_64);
        chk(mem_hit, ex[1]);
        chk(pf_hit, ex[0]);
        chk(forward, |ex);
      end
    end
    end_sim();
  end
endmodule
